// ==== dadc_capture_model.sv ====
/* capture logic of the downstream reader of the output buses
   assumes words settle before the strobe falls */
`timescale 1ns/1ps
module dadc_capture_model (
  input  wire logic        strobe_i,    // data-ready strobe
  input  wire logic        strobe_oe_i, // strobe driven
  input  wire logic [13:0] bus_a_i,     // bus a wire
  input  wire logic [13:0] bus_b_i,     // bus b wire
  input  wire logic        ovr_i,       // overrange wire
  output logic [13:0]      cap_a_o,     // last bus a word
  output logic [13:0]      cap_b_o,     // last bus b word
  output logic             cap_ovr_o    // last flag
);
  // latch on the falling strobe edge while the strobe is driven
  always_ff @(negedge strobe_i) begin
    if (strobe_oe_i) begin
      cap_a_o   <= bus_a_i;
      cap_b_o   <= bus_b_i;
      cap_ovr_o <= ovr_i;
    end
  end
endmodule : dadc_capture_model

// ==== dadc_fifo.sv ====
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock, a synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ps
module dadc_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,       // system clock
  input  wire logic             sys_rst_i,   // synchronous reset
  input  wire logic             ce_i,        // clock enable
  input  wire logic [WIDTH-1:0] in_data_i,   // word to store
  input  wire logic             in_valid_i,  // word offered
  output logic                  in_ready_o,  // room for a word
  output logic [WIDTH-1:0]      out_data_o,  // oldest word
  output logic                  out_valid_o, // a word is held
  input  wire logic             out_ready_i  // consumer takes head
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // honest flags straight from the occupancy count
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = ce_i & in_valid_i & in_ready_o;
  assign pop         = ce_i & out_ready_i & out_valid_o;

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers wrap at the depth
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
    end
  end

  // occupancy
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else if (push & ~pop) begin
      cnt_q <= cnt_q + (AW+1)'(1);
    end else if (pop & ~push) begin
      cnt_q <= cnt_q - (AW+1)'(1);
    end
  end

endmodule : dadc_fifo

// ==== dadc_map.svh ====
/*
  Constants for the dual converter output control block: register offsets,
  field positions, reset values, code words and timing figures.
  Assumes inclusion by its bare name from every file that needs them.
*/
`ifndef DADC_MAP_SVH
`define DADC_MAP_SVH

// register byte offsets on the avalon slave
`define DADC_CTRL_OFS        4'h0
`define DADC_STATUS_OFS      4'h4
`define DADC_LAST_OFS        4'h8

// control register fields and reset value
`define DADC_CTRL_HOLD_BIT   0
`define DADC_CTRL_RST        32'h0000_0000

// status register fields
`define DADC_ST_TWOS_BIT     0
`define DADC_ST_DCS_BIT      1
`define DADC_ST_PWRA_LSB     2
`define DADC_ST_PWRB_LSB     4
`define DADC_ST_RELOCKA_BIT  6
`define DADC_ST_RELOCKB_BIT  7
`define DADC_ST_OVF_BIT      8
`define DADC_ST_AVAIL_BIT    9
`define DADC_ST_OVR_BIT      10

// two's complement extremes and the offset binary conversion mask
`define DADC_TC_MAX          14'h1FFF
`define DADC_TC_MIN          14'h2000
`define DADC_OB_FLIP         14'h2000

// timing figures in their own units
`define DADC_CLK_PERIOD_NS   100
`define DADC_NAP_RECOV_EDGES 100
`define DADC_RELOCK_EDGES    100
`define DADC_SLEEP_WAKE_MS   1
`define DADC_STOP_TIME_NS    100000

`endif

// ==== dadc_output_ctl.sv ====
/*
  Digital output side of a dual 14-bit converter: word coding, saturation,
  shared overrange flag, data-ready strobe, float controls, nap and sleep,
  bus swap, and an avalon-mm register slave.
  Assumes pins and sample clocks are asynchronous to clk_i and are
  synchronised here; core words and over/under flags are on clk_i.
*/
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dadc_map.svh"

module dadc_output_ctl #(
  parameter int LATENCY          = 5,   // sample edges from sample to FIFO
  parameter int FIFO_DEPTH       = 4,   // output buffer words
  parameter int SLEEP_WAKE_CYC   =
    (`DADC_SLEEP_WAKE_MS * 1000000) / `DADC_CLK_PERIOD_NS,
  parameter int STOP_TIMEOUT_CYC =
    `DADC_STOP_TIME_NS / `DADC_CLK_PERIOD_NS
) (
  input  wire logic        clk_i,                     // 10 MHz clock
  input  wire logic        sys_rst_i,                 // sync reset, high
  input  wire logic        ce_i,                      // clock enable
  input  wire logic        chan_a_sample_clock_i,     // channel a clock pin
  input  wire logic        chan_b_sample_clock_i,     // channel b clock pin
  input  wire logic        chan_a_float_ctl_n_i,      // high floats bus a
  input  wire logic        chan_b_float_ctl_n_i,      // high floats bus b
  input  wire logic        chan_a_power_down_select_i,// channel a power-down
  input  wire logic        chan_b_power_down_select_i,// channel b power-down
  input  wire logic        bus_swap_select_i,         // high: straight buses
  input  wire logic [1:0]  format_select_i,           // four-level mode pin
  input  wire logic [13:0] chan_a_core_word_i,        // a core, two's compl.
  input  wire logic        chan_a_core_over_i,        // a above range
  input  wire logic        chan_a_core_under_i,       // a below range
  input  wire logic [13:0] chan_b_core_word_i,        // b core, two's compl.
  input  wire logic        chan_b_core_over_i,        // b above range
  input  wire logic        chan_b_core_under_i,       // b below range
  output logic [13:0]      bus_a_bits_o,              // bus a data
  output logic             bus_a_bits_oe_o,           // bus a driven
  output logic [13:0]      bus_b_bits_o,              // bus b data
  output logic             bus_b_bits_oe_o,           // bus b driven
  output logic             overrange_flag_o,          // shared overrange
  output logic             overrange_flag_oe_o,       // flag driven
  output logic             data_ready_strobe_o,       // delayed b clock
  output logic             data_ready_strobe_oe_o,    // strobe driven
  input  wire logic [3:0]  avs_address_i,             // byte address
  input  wire logic        avs_read_i,                // read request
  input  wire logic        avs_write_i,               // write request
  input  wire logic [31:0] avs_writedata_i,           // write data
  input  wire logic [3:0]  avs_byteenable_i,          // byte lanes
  output logic [31:0]      avs_readdata_o,            // read data
  output logic             avs_waitrequest_o          // stall request
);
  localparam int NPIN = 9;

  logic [NPIN-1:0]  pin_raw;
  logic [NPIN-1:0]  pin_meta_q;
  logic [NPIN-1:0]  pin_sync_q;
  logic [NPIN-1:0]  pin_prev_q;
  logic [1:0]       rise;
  logic [1:0]       pd;
  logic [1:0]       flt;
  logic [1:0]       fmt;
  logic [1:0]       relock;
  logic [1:0]       active;
  logic [14:0]      entry [2];
  logic [14:0]      tail [2];
  dadc_pkg::dadc_pwr_t pwr [2];
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [29:0]      fifo_out;
  logic             push_req;
  logic             pop_req;
  logic             swap;
  logic [31:0]      ctrl_q;
  logic             ovf_q;
  logic [13:0]      word_a_q;
  logic [13:0]      word_b_q;
  logic             ovr_q;
  logic             strobe_q;
  logic             ack_q;
  logic [31:0]      rdata_q;
  logic [31:0]      status;
  logic             wr_commit;

  // resolve the mode pin: bit1 two's complement, bit0 stabilizer on
  function automatic logic [1:0] dadc_decode(input logic [1:0] m);
    logic [1:0] r;
    r = 2'b00;
    unique case (dadc_pkg::dadc_mode_t'(m))
      dadc_pkg::DADC_MODE_GND:   r = 2'b00;
      dadc_pkg::DADC_MODE_THIRD: r = 2'b01;
      dadc_pkg::DADC_MODE_TWO3:  r = 2'b11;
      dadc_pkg::DADC_MODE_VDD:   r = 2'b10;
    endcase
    return r;
  endfunction : dadc_decode

  // clamp and code one core sample; returns {overrange, word}
  function automatic logic [14:0] dadc_code(input logic [13:0] w,
                                            input logic ov,
                                            input logic un,
                                            input logic twos);
    logic [13:0] t;
    t = w;
    if (ov) begin
      t = `DADC_TC_MAX;
    end else if (un) begin
      t = `DADC_TC_MIN;
    end
    if (!twos) begin
      t = t ^ `DADC_OB_FLIP;
    end
    return {ov | un, t};
  endfunction : dadc_code

  assign pin_raw = {format_select_i, bus_swap_select_i,
                    chan_b_power_down_select_i, chan_a_power_down_select_i,
                    chan_b_float_ctl_n_i, chan_a_float_ctl_n_i,
                    chan_b_sample_clock_i, chan_a_sample_clock_i};

  // two-stage synchroniser, then a history stage for edge finding
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      pin_prev_q <= '0;
    end else if (ce_i) begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // stabilizer samples on rising edges only, falling edges ignored
  assign rise = pin_sync_q[1:0] & ~pin_prev_q[1:0];
  assign flt  = pin_sync_q[3:2];
  assign pd   = pin_sync_q[5:4];
  assign swap = pin_sync_q[6];
  assign fmt  = dadc_decode(pin_sync_q[8:7]);
  assign entry[0] = dadc_code(chan_a_core_word_i, chan_a_core_over_i,
                              chan_a_core_under_i, fmt[1]);
  assign entry[1] = dadc_code(chan_b_core_word_i, chan_b_core_over_i,
                              chan_b_core_under_i, fmt[1]);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      dadc_pkg::dadc_pwr_t pwr_q;
      logic [23:0]         rcnt_q;
      logic                wake_slow_q;
      logic [23:0]         idle_q;
      logic                stopped_q;
      logic [7:0]          lock_q;
      logic [14:0]         pipe_q [LATENCY];

      // power state, each channel from its own pins only
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          pwr_q       <= dadc_pkg::DADC_PWR_ACTIVE;
          rcnt_q      <= '0;
          wake_slow_q <= 1'b0;
        end else if (ce_i) begin
          unique case (pwr_q)
            dadc_pkg::DADC_PWR_ACTIVE: begin
              if (pd[gi]) begin
                pwr_q <= flt[gi] ? dadc_pkg::DADC_PWR_SLEEP
                                 : dadc_pkg::DADC_PWR_NAP;
              end
            end
            dadc_pkg::DADC_PWR_NAP, dadc_pkg::DADC_PWR_SLEEP: begin
              if (pd[gi] && flt[gi]) begin
                pwr_q <= dadc_pkg::DADC_PWR_SLEEP;
              end else if (pd[gi]) begin
                pwr_q <= dadc_pkg::DADC_PWR_NAP;
              end else begin
                pwr_q       <= dadc_pkg::DADC_PWR_RECOVER;
                wake_slow_q <= (pwr_q == dadc_pkg::DADC_PWR_SLEEP);
                rcnt_q      <= (pwr_q == dadc_pkg::DADC_PWR_SLEEP)
                               ? 24'(SLEEP_WAKE_CYC)
                               : 24'(`DADC_NAP_RECOV_EDGES);
              end
            end
            dadc_pkg::DADC_PWR_RECOVER: begin
              if (pd[gi]) begin
                pwr_q <= flt[gi] ? dadc_pkg::DADC_PWR_SLEEP
                                 : dadc_pkg::DADC_PWR_NAP;
              end else if (rcnt_q <= 24'h000001 &&
                           (wake_slow_q || rise[gi])) begin
                pwr_q <= dadc_pkg::DADC_PWR_ACTIVE;
              end else if (wake_slow_q || rise[gi]) begin
                rcnt_q <= rcnt_q - 24'h000001;
              end
            end
          endcase
        end
      end

      // detect a long clock stop, then count relock edges
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          idle_q    <= '0;
          stopped_q <= 1'b0;
          lock_q    <= '0;
        end else if (ce_i) begin
          if (rise[gi]) begin
            idle_q    <= '0;
            stopped_q <= 1'b0;
            if (stopped_q && fmt[0]) begin
              lock_q <= 8'(`DADC_RELOCK_EDGES);
            end else if (lock_q != 8'h00) begin
              lock_q <= lock_q - 8'h01;
            end
          end else if (idle_q >= 24'(STOP_TIMEOUT_CYC)) begin
            stopped_q <= 1'b1;
          end else begin
            idle_q <= idle_q + 24'h000001;
          end
        end
      end

      // fixed-latency pipeline, stalled by a full output buffer
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          for (int k = 0; k < LATENCY; k++) begin
            pipe_q[k] <= '0;
          end
        end else if (ce_i && rise[gi] && fifo_in_ready &&
                     pwr_q == dadc_pkg::DADC_PWR_ACTIVE) begin
          pipe_q[0] <= entry[gi];
          for (int k = 1; k < LATENCY; k++) begin
            pipe_q[k] <= pipe_q[k-1];
          end
        end
      end

      assign tail[gi]   = pipe_q[LATENCY-1];
      assign pwr[gi]    = pwr_q;
      assign relock[gi] = (lock_q != 8'h00);
      assign active[gi] = ~pd[gi] & (pwr_q == dadc_pkg::DADC_PWR_ACTIVE |
                                     pwr_q == dadc_pkg::DADC_PWR_RECOVER);
    end
  endgenerate

  // channel b edge moves one word pair into the buffer and, unless hold is set, one out
  assign push_req = rise[1];
  assign pop_req  = rise[1] & ~ctrl_q[`DADC_CTRL_HOLD_BIT];

  dadc_fifo #(
    .WIDTH (30),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .ce_i        (ce_i),
    .in_data_i   ({tail[1], tail[0]}),
    .in_valid_i  (push_req),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop_req)
  );

  // output words: swap steers channels to buses, shared flag ors both
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      word_a_q <= '0;
      word_b_q <= '0;
      ovr_q    <= 1'b0;
    end else if (ce_i && pop_req && fifo_out_valid) begin
      word_a_q <= swap ? fifo_out[13:0] : fifo_out[28:15];
      word_b_q <= swap ? fifo_out[28:15] : fifo_out[13:0];
      ovr_q    <= fifo_out[14] | fifo_out[29];
    end
  end

  // strobe trails the synchronised b clock so data settle before its fall
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      strobe_q <= 1'b0;
    end else if (ce_i) begin
      strobe_q <= pin_prev_q[1];
    end
  end

  assign bus_a_bits_o           = word_a_q;
  assign bus_b_bits_o           = word_b_q;
  assign overrange_flag_o       = ovr_q;
  assign data_ready_strobe_o    = strobe_q;
  // float control and power-down float each channel's data pins; the strobe floats on b power-down only
  assign bus_a_bits_oe_o        = ~flt[0] & ~pd[0] & active[0];
  assign bus_b_bits_oe_o        = ~flt[1] & ~pd[1] & active[1];
  assign overrange_flag_oe_o    = ~flt[0] & ~pd[0] & active[0];
  assign data_ready_strobe_oe_o = ~pd[1] & active[1];

  // sticky buffer overflow: a word pair refused at a full buffer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ovf_q <= 1'b0;
    end else if (ce_i) begin
      if (push_req && !fifo_in_ready) begin
        ovf_q <= 1'b1;
      end else if (wr_commit && avs_address_i == `DADC_STATUS_OFS &&
                   avs_byteenable_i[1] &&
                   avs_writedata_i[`DADC_ST_OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  always_comb begin
    status = '0;
    status[`DADC_ST_TWOS_BIT]                 = fmt[1];
    status[`DADC_ST_DCS_BIT]                  = fmt[0];
    status[`DADC_ST_PWRA_LSB +: 2]            = pwr[0];
    status[`DADC_ST_PWRB_LSB +: 2]            = pwr[1];
    status[`DADC_ST_RELOCKA_BIT]              = relock[0];
    status[`DADC_ST_RELOCKB_BIT]              = relock[1];
    status[`DADC_ST_OVF_BIT]                  = ovf_q;
    status[`DADC_ST_AVAIL_BIT]                = fifo_out_valid;
    status[`DADC_ST_OVR_BIT]                  = ovr_q;
  end

  // avalon slave: one wait cycle, then the answer
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_commit         = ce_i & avs_write_i & ack_q;
  assign avs_readdata_o    = rdata_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else if (ce_i) begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
      if (avs_read_i && !ack_q) begin
        unique case (avs_address_i)
          `DADC_CTRL_OFS:   rdata_q <= ctrl_q;
          `DADC_STATUS_OFS: rdata_q <= status;
          `DADC_LAST_OFS:   rdata_q <= {2'h0, word_b_q, 2'h0, word_a_q};
          default:          rdata_q <= '0;
        endcase
      end
    end
  end

  // control register, low byte only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `DADC_CTRL_RST;
    end else if (wr_commit && avs_address_i == `DADC_CTRL_OFS &&
                 avs_byteenable_i[0]) begin
      ctrl_q[`DADC_CTRL_HOLD_BIT] <= avs_writedata_i[`DADC_CTRL_HOLD_BIT];
    end
  end

endmodule : dadc_output_ctl

// ==== dadc_output_ctl_props.sv ====
/* assertions on the output control ports
   assumes binding to dadc_output_ctl and one clock domain */
`timescale 1ns/1ps
module dadc_output_ctl_props (
  input wire logic        clk_i,                      // clock
  input wire logic        sys_rst_i,                  // reset
  input wire logic        chan_b_sample_clock_i,      // b clock pin
  input wire logic        chan_a_float_ctl_n_i,       // a float
  input wire logic        chan_b_float_ctl_n_i,       // b float
  input wire logic        chan_a_power_down_select_i, // a power-down
  input wire logic        chan_b_power_down_select_i, // b power-down
  input wire logic [13:0] bus_a_bits_o,               // bus a word
  input wire logic        bus_a_bits_oe_o,            // bus a driven
  input wire logic        bus_b_bits_oe_o,            // bus b driven
  input wire logic        overrange_flag_oe_o,        // flag driven
  input wire logic        data_ready_strobe_o,        // strobe
  input wire logic        data_ready_strobe_oe_o      // strobe driven
);
  // one domain, reset cancels every attempt
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // float and power-down pins release the outputs once synchronised
  property p_flt_a;
    chan_a_float_ctl_n_i [*6] |-> !bus_a_bits_oe_o && !overrange_flag_oe_o;
  endproperty
  a_flt_a: assert property (p_flt_a) else $error("bus a driven");
  property p_flt_b;
    chan_b_float_ctl_n_i [*6] |-> !bus_b_bits_oe_o;
  endproperty
  a_flt_b: assert property (p_flt_b) else $error("bus b driven");
  property p_pd_a;
    chan_a_power_down_select_i [*6]
      |-> !overrange_flag_oe_o && !bus_a_bits_oe_o;
  endproperty
  a_pd_a: assert property (p_pd_a) else $error("a outputs driven");
  property p_pd_b;
    chan_b_power_down_select_i [*6]
      |-> !data_ready_strobe_oe_o && !bus_b_bits_oe_o;
  endproperty
  a_pd_b: assert property (p_pd_b) else $error("b outputs driven");
  // a running channel drives whatever the other one does
  property p_run_a;
    (!chan_a_power_down_select_i && !chan_a_float_ctl_n_i) [*6]
      |-> bus_a_bits_oe_o && overrange_flag_oe_o;
  endproperty
  a_run_a: assert property (p_run_a) else $error("a not driven");
  property p_run_b;
    (!chan_b_power_down_select_i && !chan_b_float_ctl_n_i) [*6]
      |-> bus_b_bits_oe_o && data_ready_strobe_oe_o;
  endproperty
  a_run_b: assert property (p_run_b) else $error("b not driven");
  // strobe follows the b clock pin and stays up a while
  property p_strb;
    $rose(data_ready_strobe_o)
      |-> $past(chan_b_sample_clock_i, 4) ##1 data_ready_strobe_o [*2];
  endproperty
  a_strb: assert property (p_strb) else $error("strobe not b clock");
  // a new word is followed by a strobe rise
  property p_word;
    $changed(bus_a_bits_o) |=> $rose(data_ready_strobe_o);
  endproperty
  a_word: assert property (p_word) else $error("word without strobe");
endmodule : dadc_output_ctl_props

bind dadc_output_ctl dadc_output_ctl_props i_dadc_output_ctl_props (
  .clk_i, .sys_rst_i, .chan_b_sample_clock_i, .chan_a_float_ctl_n_i,
  .chan_b_float_ctl_n_i, .chan_a_power_down_select_i,
  .chan_b_power_down_select_i, .bus_a_bits_o, .bus_a_bits_oe_o,
  .bus_b_bits_oe_o, .overrange_flag_oe_o, .data_ready_strobe_o,
  .data_ready_strobe_oe_o);

// ==== dadc_output_ctl_tb_top.sv ====
/* self-checking bench for the converter output control block
   assumes the capture model and the bound checker beside it */
`timescale 1ns/1ps
module dadc_output_ctl_tb_top;
  localparam int FLUSH = 12;
  logic        clk_i = 1'b0;
  logic        rst = 1'b1;
  logic        smp = 1'b0;
  logic        fa = 1'b0, fb = 1'b0, pa = 1'b0, pb = 1'b0;
  logic        swp = 1'b1, ov_a = 1'b0, un_b = 1'b0;
  logic        ce = 1'b1, run = 1'b1, un_a = 1'b0, ov_b = 1'b0;
  logic [13:0] wa = 14'h0000, wb = 14'h1FFF;
  logic [1:0]  fmt = 2'h0;
  logic [3:0]  adr = 4'h0, be = 4'h0;
  logic        rd_r = 1'b0, wr_r = 1'b0;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [13:0] ba, bb, ca, cb;
  logic        bao, bbo, ovr, ovo, stb, sto, wrq, co;
  int          num_errors = 0, samples_checked = 0;

  // the b clock also clocks channel a, so both channels sample on the same edges
  dadc_output_ctl #(.LATENCY(5), .FIFO_DEPTH(4), .SLEEP_WAKE_CYC(20),
    .STOP_TIMEOUT_CYC(30)) i_dadc_output_ctl (.clk_i(clk_i),
    .sys_rst_i(rst), .ce_i(ce), .chan_a_sample_clock_i(smp),
    .chan_b_sample_clock_i(smp), .chan_a_float_ctl_n_i(fa),
    .chan_b_float_ctl_n_i(fb), .chan_a_power_down_select_i(pa),
    .chan_b_power_down_select_i(pb), .bus_swap_select_i(swp),
    .format_select_i(fmt), .chan_a_core_word_i(wa),
    .chan_a_core_over_i(ov_a), .chan_a_core_under_i(un_a),
    .chan_b_core_word_i(wb), .chan_b_core_over_i(ov_b),
    .chan_b_core_under_i(un_b), .bus_a_bits_o(ba), .bus_a_bits_oe_o(bao),
    .bus_b_bits_o(bb), .bus_b_bits_oe_o(bbo), .overrange_flag_o(ovr),
    .overrange_flag_oe_o(ovo), .data_ready_strobe_o(stb),
    .data_ready_strobe_oe_o(sto), .avs_address_i(adr), .avs_read_i(rd_r),
    .avs_write_i(wr_r), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wrq));
  // released wires show the inverse of the last word
  dadc_capture_model i_dadc_capture_model (.strobe_i(stb),
    .strobe_oe_i(sto), .bus_a_i(bao ? ba : ~ba), .bus_b_i(bbo ? bb : ~bb),
    .ovr_i(ovo ? ovr : ~ovr), .cap_a_o(ca), .cap_b_o(cb), .cap_ovr_o(co));

  // system clock, and a sample clock that starts after reset
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #1030;
    forever #400 smp = ~smp & run;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one avalon access, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    be <= b;
    wr_r <= w;
    rd_r <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wrq !== 1'b0 && n < 20);
    v = rdat;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
    if (n >= 20) num_errors++;
  endtask : av

  // read the status register into v
  task automatic rs;
    av(1'b0, 4'h4, 32'h0, 4'hF);
  endtask : rs

  task automatic wait_b(input int n);
    repeat (n) @(posedge smp);
    repeat (6) @(posedge clk_i);
  endtask : wait_b

  function automatic logic [13:0] code(logic [13:0] w, logic o, logic u,
                                       logic tc);
    logic [13:0] r;
    r = o ? 14'h1FFF : (u ? 14'h2000 : w);
    return tc ? r : r ^ 14'h2000;
  endfunction : code

  // every format code: in range, over on a, under on b, under a over b
  task automatic t_coding;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clk_i);
        fmt <= 2'(m);
        ov_a <= (k == 1);
        un_b <= (k == 2);
        un_a <= (k == 3);
        ov_b <= (k == 3);
        wait_b(FLUSH);
        chk(ca, code(wa, k == 1, k == 3, m > 1));
        chk(cb, code(wb, k == 3, k == 2, m > 1));
        chk(co, k != 0);
      end
      rs();
      chk(v[1:0], {m == 1 || m == 2, m > 1});
    end
  endtask : t_coding

  task automatic t_swap;
    @(posedge clk_i);
    {ov_a, un_a, ov_b, un_b} <= 4'h0;
    swp <= 1'b0;
    wait_b(FLUSH);
    chk({ca, cb}, {14'h1FFF, 14'h0000});
    swp <= 1'b1;
    wait_b(FLUSH);
    chk({ca, cb}, {14'h0000, 14'h1FFF});
    av(1'b0, 4'h8, 32'h0, 4'hF);
    chk(v, 32'h1FFF_0000);
  endtask : t_swap

  // float and nap on a, nap and sleep on b, one channel at a time
  task automatic t_power;
    @(posedge clk_i);
    fa <= 1'b1;
    wait_b(2);
    chk({bao, ovo, bbo, sto}, 4'h3);
    fa <= 1'b0;
    pa <= 1'b1;
    wait_b(2);
    chk({bao, ovo, bbo, sto}, 4'h3);
    rs();
    chk(v[3:2], 2'h1);
    pa <= 1'b0;
    pb <= 1'b1;
    wait_b(2);
    chk({bao, ovo, bbo, sto}, 4'hC);
    rs();
    chk(v[5:4], 2'h1);
    fb <= 1'b1;
    wait_b(2);
    rs();
    chk(v[5:4], 2'h2);
    pb <= 1'b0;
    fb <= 1'b0;
    repeat (5) @(posedge clk_i);
    rs();
    chk(v[5:4], 2'h3);
    repeat (30) @(posedge clk_i);
    rs();
    chk(v[5:4], 2'h0);
    pb <= 1'b1;
    wait_b(2);
    pb <= 1'b0;
    wait_b(90);
    rs();
    chk(v[5:4], 2'h3);
    wait_b(15);
    rs();
    chk(v[5:4], 2'h0);
  endtask : t_power

  // a frozen clock enable stops the idle count; a real stop relocks
  task automatic t_relock;
    @(posedge clk_i);
    fmt <= 2'h1;
    run <= 1'b0;
    repeat (10) @(posedge clk_i);
    ce <= 1'b0;
    repeat (60) @(posedge clk_i);
    ce <= 1'b1;
    run <= 1'b1;
    wait_b(2);
    rs();
    chk(v[7:6], 2'h0);
    run <= 1'b0;
    repeat (60) @(posedge clk_i);
    run <= 1'b1;
    wait_b(2);
    rs();
    chk(v[7:6], 2'h3);
    wait_b(100);
    rs();
    chk(v[7:6], 2'h0);
  endtask : t_relock

  // hold the buffer until it overflows, clear, unmapped place
  task automatic t_buffer;
    av(1'b1, 4'h0, 32'h1, 4'h1);
    wait_b(8);
    rs();
    chk(v[9:8], 2'h3);
    av(1'b0, 4'h0, 32'h0, 4'hF);
    chk(v, 32'h1);
    av(1'b1, 4'h0, 32'h0, 4'h1);
    wait_b(FLUSH);
    av(1'b1, 4'h4, 32'h100, 4'h2);
    rs();
    chk(v[8], 1'b0);
    av(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF);
    av(1'b0, 4'hC, 32'h0, 4'hF);
    chk(v, 32'h0);
  endtask : t_buffer

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  // watchdog well beyond the expected run
  initial begin
    #3000000;
    num_errors++;
    print_verdict();
  end

  // release reset, then run the coding, swap, power, relock and buffer tests
  initial begin
    repeat (2) @(posedge clk_i);
    rst <= 1'b0;
    t_coding();
    t_swap();
    t_power();
    t_relock();
    t_buffer();
    print_verdict();
  end
endmodule : dadc_output_ctl_tb_top

// ==== dadc_pkg.sv ====
/*
  Types shared by the dual converter output control block.
  Assumes the constants header is compiled alongside.
*/
package dadc_pkg;

  // four-level format select pin, as resolved by the pad comparators
  typedef enum logic [1:0] {
    DADC_MODE_GND   = 2'b00,
    DADC_MODE_THIRD = 2'b01,
    DADC_MODE_TWO3  = 2'b10,
    DADC_MODE_VDD   = 2'b11
  } dadc_mode_t;

  // per-channel power state
  typedef enum logic [1:0] {
    DADC_PWR_ACTIVE  = 2'b00,
    DADC_PWR_NAP     = 2'b01,
    DADC_PWR_SLEEP   = 2'b10,
    DADC_PWR_RECOVER = 2'b11
  } dadc_pwr_t;

endpackage : dadc_pkg
